// *** hw/gst_timer_top.v ***
// Three gated 16-bit timer cores with clock select, prescaler and APB access.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "gst_consts.vh"
module gst_timer_top #(
  parameter NT = `GST_NUM_TMR,   // Timer instances.
  parameter CW = 16              // Counter width.
) (
  input  wire          pclk,                  // System clock.
  input  wire          presetn,               // Async reset, active low.
  input  wire          psel,                  // APB select.
  input  wire          penable,               // APB enable.
  input  wire          pwrite,                // APB direction.
  input  wire [7:0]    paddr,                 // APB byte address.
  input  wire [31:0]   pwdata,                // APB write data.
  output wire [31:0]   prdata,                // APB read data.
  output wire          pready,                // APB ready.
  output wire          pslverr,               // APB error, unmapped.
  input  wire [NT-1:0] ext_count_clock_pin,   // External count clocks.
  input  wire          low_freq_internal_osc, // Low-frequency oscillator.
  input  wire          crystal_input_pin,     // Crystal oscillator input.
  input  wire [NT-1:0] gate_qual,             // Gate qualifiers, same clock.
  input  wire          sleep_mode,            // Processor asleep, level.
  output wire [NT-1:0] overflow_flag,         // Sticky overflow flags.
  output wire          wake_req,              // Wake pulse on overflow in sleep.
  output wire          secondary_osc_on,      // Crystal oscillator running.
  output wire          crystal_output_pin     // Crystal amplifier output.
);

  //****************************************************************
  // Functions
  //****************************************************************

  // True when the prescale count has reached the end of its period.
  function pre_done;
    input [2:0] pre;
    input [1:0] ps;
    reg   [2:0] mask;
    begin
      mask     = (3'h1 << ps) - 3'h1;
      pre_done = ((pre & mask) == mask);
    end
  endfunction

  // True when the byte address names a mapped register word.
  function addr_hit;
    input [7:0] a;
    begin
      addr_hit = (a[1:0] == 2'h0) && (a[7] == 1'b0) &&
                 (a[6:5] < NT) && (a[4:2] <= `GST_REG_STAT);
    end
  endfunction

  //****************************************************************
  // Declarations
  //****************************************************************

  reg  [31:0]   prdata_r;
  reg           pready_r;
  reg           pslverr_r;
  reg  [1:0]    phase_r;
  reg           wake_r;
  reg           sosc_on_r;
  reg           xout_r;
  reg  [31:0]   rd_data;

  wire [4:0]    sy_lvl;
  wire [4:0]    sy_rise;
  wire [4:0]    sy_fall;
  wire          acc_ok;
  wire [1:0]    acc_idx;
  wire [2:0]    acc_reg;
  wire          wr_fire;
  wire          phase_last;
  wire [NT*8-1:0]  ctl_all;
  wire [NT-1:0]    gen_all;
  wire [NT*CW-1:0] cnt_all;
  wire [NT-1:0]    ovf_all;
  wire [NT-1:0]    wake_all;
  wire [NT-1:0]    sosc_all;

  //****************************************************************
  // Input synchronizers
  //****************************************************************

  // Pins, low-frequency oscillator and crystal enter through two flops.
  gst_sync #(
    .W (5)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({crystal_input_pin, low_freq_internal_osc,
             ext_count_clock_pin[2:0]}),
    .lvl   (sy_lvl),
    .rise  (sy_rise),
    .fall  (sy_fall)
  );

  //****************************************************************
  // APB slave
  //****************************************************************

  // Address fields shared by every timer instance.
  assign acc_ok  = addr_hit(paddr);
  assign acc_idx = paddr[6:5];
  assign acc_reg = paddr[4:2];
  assign wr_fire = psel & penable & pready_r & pwrite & acc_ok;

  // Read data multiplexer over the selected instance.
  always @* begin
    rd_data = 32'h0000_0000;
    if (acc_ok) begin
      case (acc_reg)
        `GST_REG_CTRL: rd_data[7:0] = ctl_all[acc_idx*8 +: 8];
        `GST_REG_GATE: begin
          rd_data[`GST_GATE_EN]   = gen_all[acc_idx];
          rd_data[`GST_GATE_QUAL] = gate_qual[acc_idx];
        end
        `GST_REG_CNTL: rd_data[7:0] = cnt_all[acc_idx*CW +: 8];
        `GST_REG_CNTH: rd_data[7:0] = cnt_all[acc_idx*CW + 8 +: 8];
        `GST_REG_STAT: rd_data[`GST_STAT_OVF] = ovf_all[acc_idx];
        default:       rd_data = 32'h0000_0000;
      endcase
    end
  end

  // One wait state: ready rises in the second access cycle.
  // Count bytes are sampled one edge before completion.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~acc_ok;
      if (psel & penable & ~pready_r & ~pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  //****************************************************************
  // Instruction phase counter
  //****************************************************************

  // Four system periods make one instruction cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign phase_last = (phase_r == `GST_PHASE_LAST);

  //****************************************************************
  // Timer instances
  //****************************************************************

  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : tmr
      reg  [7:0]    ctl_r;
      reg           gate_en_r;
      reg  [CW-1:0] cnt_r;
      reg  [2:0]    pre_r;
      reg           armed_r;
      reg           pend_r;
      reg           ovf_r;
      reg           tick;

      wire          sel_me = wr_fire & (acc_idx == g);
      wire          wr_ctl = sel_me & (acc_reg == `GST_REG_CTRL);
      wire          wr_gen = sel_me & (acc_reg == `GST_REG_GATE);
      wire          wr_lo  = sel_me & (acc_reg == `GST_REG_CNTL);
      wire          wr_hi  = sel_me & (acc_reg == `GST_REG_CNTH);
      wire          wr_st  = sel_me & (acc_reg == `GST_REG_STAT);
      wire          on     = ctl_r[`GST_CTL_ON];
      wire          async  = ctl_r[`GST_CTL_SYNC];
      wire          sosc   = ctl_r[`GST_CTL_SOSC];
      wire [1:0]    ps     = ctl_r[`GST_CTL_PS_LO +: 2];
      wire [1:0]    cs     = ctl_r[`GST_CTL_CS_LO +: 2];
      // The crystal replaces the pin when its oscillator is enabled.
      wire          x_rise = sosc ? sy_rise[4] : sy_rise[g];
      wire          x_fall = sosc ? sy_fall[4] : sy_fall[g];
      // Gate qualifies counting only while gate_enable is set.
      wire          run    = on & (~gate_en_r | gate_qual[g]);
      // In sleep only the asynchronous pin mode keeps counting.
      wire          awake  = ~sleep_mode |
                             ((cs == `GST_CS_PIN) & async);
      wire          adv    = run & awake & tick & pre_done(pre_r, ps);
      wire          wr_cnt = wr_lo | wr_hi;
      wire          ovf_set = adv & ~wr_cnt & (cnt_r == `GST_CNT_MAX);

      // Select the count tick from the chosen clock source.
      always @* begin
        tick = 1'b0;
        case (cs)
          `GST_CS_SYS:   tick = 1'b1;
          `GST_CS_INSTR: tick = phase_last;
          `GST_CS_LFO:   tick = sy_rise[3];
          `GST_CS_PIN:   begin
            // Unsynchronized mode skips phase alignment.
            if (async) begin
              tick = x_rise & armed_r;
            end else begin
              tick = pend_r & phase_last;
            end
          end
          default:       tick = 1'b0;
        endcase
      end

      // Control and gate enable registers.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_r     <= `GST_CTL_RST;
          gate_en_r <= 1'b0;
        end else begin
          if (wr_ctl) begin
            ctl_r <= pwdata[7:0];
          end
          if (wr_gen) begin
            gate_en_r <= pwdata[`GST_GATE_EN];
          end
        end
      end

      // Falling edge arming and pending synchronized edge.
      // Switching modes drops or adds at most one edge.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          armed_r <= 1'b0;
          pend_r  <= 1'b0;
        end else begin
          if (wr_cnt | ~on) begin
            armed_r <= 1'b0;
          end else if (x_fall) begin
            armed_r <= 1'b1;
          end
          if (wr_cnt | ~on | async) begin
            pend_r <= 1'b0;
          end else if (x_rise & armed_r) begin
            pend_r <= 1'b1;
          end else if (phase_last) begin
            pend_r <= 1'b0;
          end
        end
      end

      // Hidden prescale counter, cleared by any count write.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pre_r <= 3'h0;
        end else if (wr_cnt) begin
          pre_r <= 3'h0;
        end else if (run & awake & tick) begin
          pre_r <= pre_r + 3'h1;
        end
      end

      // Counter with byte writes taking priority over an increment.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= `GST_CNT_RST;
        end else if (wr_lo) begin
          cnt_r[7:0] <= pwdata[7:0];
        end else if (wr_hi) begin
          cnt_r[15:8] <= pwdata[7:0];
        end else if (adv) begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end

      // Sticky overflow flag; a new overflow beats a clear.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ovf_r <= 1'b0;
        end else if (ovf_set) begin
          ovf_r <= 1'b1;
        end else if (wr_st & pwdata[`GST_STAT_OVF]) begin
          ovf_r <= 1'b0;
        end
      end

      // Flatten per-instance state for the shared read path.
      assign ctl_all[g*8 +: 8]   = ctl_r;
      assign gen_all[g]          = gate_en_r;
      assign cnt_all[g*CW +: CW] = cnt_r;
      assign ovf_all[g]          = ovf_r;
      assign wake_all[g]         = ovf_set & sleep_mode;
      assign sosc_all[g]         = sosc;
      assign overflow_flag[g]    = ovf_r;
    end
  endgenerate

  //****************************************************************
  // Wake and secondary oscillator
  //****************************************************************

  // Wake pulse follows an overflow taken while asleep.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= |wake_all;
    end
  end

  // Oscillator runs while any instance enables it, sleep or not.
  // The amplifier output inverts the settled crystal input while any instance enables it, and stays low otherwise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sosc_on_r <= 1'b0;
      xout_r    <= 1'b0;
    end else begin
      sosc_on_r <= |sosc_all;
      xout_r    <= (|sosc_all) & ~sy_lvl[4];
    end
  end

  assign wake_req           = wake_r;
  assign secondary_osc_on   = sosc_on_r;
  assign crystal_output_pin = xout_r;

endmodule

// *** hw/gst_consts.vh ***
// Register map, field positions, reset values and counts of the timer block.
`ifndef GST_CONSTS_VH
`define GST_CONSTS_VH

// Number of identical timer instances.
`define GST_NUM_TMR     3
// Byte address stride between timer instances.
`define GST_TMR_STRIDE  8'h20

// Word index of each register inside one timer instance.
`define GST_REG_CTRL    3'h0
`define GST_REG_GATE    3'h1
`define GST_REG_CNTL    3'h2
`define GST_REG_CNTH    3'h3
`define GST_REG_STAT    3'h4

// Field positions in the timer_control register.
`define GST_CTL_ON      0
`define GST_CTL_SYNC    2
`define GST_CTL_SOSC    3
`define GST_CTL_PS_LO   4
`define GST_CTL_CS_LO   6

// Field positions in the gate_control and status registers.
`define GST_GATE_EN     0
`define GST_GATE_QUAL   1
`define GST_STAT_OVF    0

// Reset values and the count maximum.
`define GST_CTL_RST     8'h00
`define GST_CNT_RST     16'h0000
`define GST_CNT_MAX     16'hFFFF

// Count clock select encodings.
`define GST_CS_INSTR    2'h0
`define GST_CS_SYS      2'h1
`define GST_CS_PIN      2'h2
`define GST_CS_LFO      2'h3

// Last phase of a four-period instruction cycle.
`define GST_PHASE_LAST  2'h3

`endif

// *** hw/gst_sync.v ***
// Two-stage synchronizer with edge detection for slow external clocks.
`timescale 1ns/1ps
module gst_sync #(
  parameter W = 5
) (
  input  wire         clk,     // System clock.
  input  wire         rst_n,   // Asynchronous reset, active low.
  input  wire [W-1:0] d,       // Asynchronous inputs.
  output wire [W-1:0] lvl,     // Synchronized levels.
  output wire [W-1:0] rise,    // One-cycle rising edge pulses.
  output wire [W-1:0] fall     // One-cycle falling edge pulses.
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  //****************************************************************
  // Synchronizer chain
  //****************************************************************
  // The first stage feeds only the second stage; edges use stages 2 and 3.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edge pulses from the settled stages.
  assign lvl  = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

endmodule

// *** sim/gst_timer_props.sv ***
// Port-level concurrent checks for the three-timer block.
`timescale 1ns/1ps
module gst_timer_props #(
  parameter NT = 3,  // Timer instances.
  parameter CW = 16  // Counter width.
) (
  input wire          pclk,                  // System clock.
  input wire          presetn,               // Reset, active low.
  input wire          psel,                  // Bus select.
  input wire          penable,               // Bus enable.
  input wire          pwrite,                // Bus direction.
  input wire [7:0]    paddr,                 // Bus address.
  input wire [31:0]   pwdata,                // Bus write data.
  input wire [31:0]   prdata,                // Bus read data.
  input wire          pready,                // Bus ready.
  input wire          pslverr,               // Bus error.
  input wire [NT-1:0] ext_count_clock_pin,   // Pin clocks.
  input wire          low_freq_internal_osc, // Slow oscillator.
  input wire          crystal_input_pin,     // Crystal input.
  input wire [NT-1:0] gate_qual,             // Gate qualifiers.
  input wire          sleep_mode,            // Processor asleep.
  input wire [NT-1:0] overflow_flag,         // Overflow flags.
  input wire          wake_req,              // Wake pulse.
  input wire          secondary_osc_on,      // Crystal running.
  input wire          crystal_output_pin     // Crystal drive.
);
  // ****************************************************************
  // Transfer decodes and properties
  // ****************************************************************
  // Decodes of a completing write and of the address map holes.
  wire done_w = psel & penable & pready & pwrite;
  wire unmap  = paddr[7] | (paddr[6:5] == 2'h3) | (paddr[4:2] > 3'h4)
                | (paddr[1:0] != 2'h0);
  wire ctl_w  = done_w & ~unmap & (paddr[4:0] == 5'h00);
  wire sosc_w = ctl_w & pwdata[3];
  wire clr_w  = done_w & (paddr == 8'h10) & pwdata[0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready did not follow exactly one wait cycle");
  chk_ready_sel: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready outside an access phase");
  chk_err_map: assert property (pready |-> pslverr == unmap)
    else $error("error response does not match the address map");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned nonzero data");
  chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read completion");
  chk_ovf_clear: assert property ($fell(overflow_flag[0])
    |-> $past(clr_w))
    else $error("overflow flag dropped without a clearing write");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  chk_wake_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request while awake");
  chk_sosc_start: assert property ($rose(secondary_osc_on)
    |-> $past(sosc_w, 2))
    else $error("oscillator started without its enable write");
  chk_sosc_sleep: assert property (secondary_osc_on && sleep_mode && !ctl_w
    && !$past(ctl_w) |=> secondary_osc_on)
    else $error("oscillator stopped during sleep");
  chk_xout_gate: assert property (crystal_output_pin
    |-> secondary_osc_on)
    else $error("crystal drive active while oscillator off");
endmodule

bind gst_timer_top gst_timer_props #(.NT(NT), .CW(CW)) u_props (.*);

// *** sim/gst_ext_src.sv ***
// Model of the external clock pin, slow oscillator and crystal.
`timescale 1ns/1ps
module gst_ext_src #(
  parameter LFO_HALF  = 100, // Slow oscillator half period, ns.
  parameter XTAL_HALF = 200, // Crystal half period, ns.
  parameter PIN_HALF  = 100  // Pin pulse half period, ns.
) (
  output reg       lfo,    // Slow oscillator.
  output reg [2:0] pin,    // Pin clocks, idle low.
  output reg       xtal,   // Crystal waveform.
  input  wire      osc_en  // Oscillator enabled by the block.
);
  // ****************************************************************
  // Waveforms
  // ****************************************************************
  // Start all sources low.
  initial begin
    lfo = 1'b0;
    pin = 3'h0;
    xtal = 1'b0;
  end
  // The slow oscillator runs free.
  always #(LFO_HALF) lfo = ~lfo;
  // The crystal swings only while enabled and stands low otherwise.
  always #(XTAL_HALF) xtal = osc_en ? ~xtal : 1'b0;
  // Emits rising then falling edges, starting and ending low.
  task pulses(input integer n);
    repeat (n) begin
      #(PIN_HALF) pin = 3'h7;
      #(PIN_HALF) pin = 3'h0;
    end
  endtask
endmodule

// *** sim/test_gated_sixteen_bit_timer_core.sv ***
// Self-checking bench for the three-timer block over its register bus.
`timescale 1ns/1ps
module test_gated_sixteen_bit_timer_core;
  localparam CTRL = 8'h00, GATE = 8'h04, LO = 8'h08, HI = 8'h0C;
  localparam STAT = 8'h10;
  reg         pclk, presetn, psel, penable, pwrite, slp, wake_seen, e;
  reg         xo_seen;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, r;
  reg  [2:0]  gq;
  reg  [15:0] c1, c2;
  wire [31:0] prdata;
  wire        pready, pslverr, wake_req, sosc_on, lfo, xtal, xo;
  wire [2:0]  pin, ovf;
  integer     fails, n_compared, cyc, i, w;
  reg  [7:0]  ctl_t [0:5];
  integer     mul_t [0:5];
`define CHK(a, b) begin n_compared = n_compared + 1; \
  if ((a) !== (b)) begin fails = fails + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

  // ****************************************************************
  // Design, sources, clock and watchdog
  // ****************************************************************
  gst_timer_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(pin), .low_freq_internal_osc(lfo),
    .crystal_input_pin(xtal), .gate_qual(gq), .sleep_mode(slp),
    .overflow_flag(ovf), .wake_req(wake_req), .secondary_osc_on(sosc_on),
    .crystal_output_pin(xo));
  gst_ext_src src (.lfo(lfo), .pin(pin), .xtal(xtal), .osc_en(sosc_on));

  // Clock of 20 ns period.
  always #10 pclk = ~pclk;
  // Counts cycles, catches wake pulses and cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) wake_seen <= 1'b1;
    if (xo === 1'b1) xo_seen <= 1'b1;
    if (cyc == 60000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  // Prints the counts and the verdict, then stops.
  task end_sim;
    begin
      $display("compared=%0d failed=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // One bus transfer; waits for ready, then idles one cycle.
  task apb(input wrt, input [7:0] a, input [7:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wrt;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // Reads the 16-bit count of timer 0 into c2.
  task get_cnt;
    begin
      rd(LO);
      c2[7:0] = r[7:0];
      rd(HI);
      c2[15:8] = r[7:0];
    end
  endtask
  // Clears the count, runs k cycles from an aligned phase, stops.
  task run(input [7:0] ctl, input [7:0] gate, input integer k);
    begin
      wr(LO, 8'h00);
      wr(HI, 8'h00);
      wr(GATE, gate);
      while (cyc % 20 != 0) @(posedge pclk);
      wr(CTRL, ctl);
      repeat (k) @(posedge pclk);
      wr(CTRL, ctl & 8'hFE);
      get_cnt;
    end
  endtask
  // Presets the count, sends n pin pulses, stops.
  task run_pin(input [7:0] ctl, input [15:0] pre, input integer n);
    begin
      wr(LO, pre[7:0]);
      wr(HI, pre[15:8]);
      wr(CTRL, ctl);
      src.pulses(n);
      repeat (10) @(posedge pclk);
      wr(CTRL, 8'h00);
      get_cnt;
    end
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // Sources with their cycles per count: sys/4, sys, sys with
  // divide 2, 4, 8, slow oscillator.
  initial begin
    {pclk, presetn, psel, penable, pwrite, slp, wake_seen, xo_seen} = 8'h00;
    {paddr, pwdata, gq} = 43'h0;
    {fails, n_compared, cyc} = 0;
    {ctl_t[0], ctl_t[1], ctl_t[2]} = {8'h01, 8'h41, 8'h51};
    {ctl_t[3], ctl_t[4], ctl_t[5]} = {8'h61, 8'h71, 8'hC1};
    {mul_t[0], mul_t[1], mul_t[2]} = {32'h4, 32'h1, 32'h2};
    {mul_t[3], mul_t[4], mul_t[5]} = {32'h4, 32'h8, 32'hA};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h20); `CHK(r, 32'h0)
    rd(8'h48); `CHK(r, 32'h0)
    for (i = 0; i < 2; i = i + 1) begin
      rd(i ? 8'h60 : 8'h14);
      `CHK({e, r}, 33'h100000000)
    end
    for (i = 0; i < 6; i = i + 1) begin
      run(ctl_t[i], 8'h00, 40);
      c1 = c2;
      run(ctl_t[i], 8'h00, 40 + 100 * mul_t[i]);
      `CHK(c2 - c1, 16'h0064)
    end
    run(8'h40, 8'h00, 100); `CHK(c2, 16'h0)
    run(8'h41, 8'h01, 100); `CHK(c2, 16'h0)
    gq <= 3'h7;
    run(8'h41, 8'h01, 40);
    c1 = c2;
    rd(GATE); `CHK(r, 32'h0000_0003)
    run(8'h41, 8'h00, 40); `CHK(c2, c1)
    wr(CTRL, 8'h41);
    rd(CTRL); `CHK(r, 32'h0000_0041)
    wr(HI, 8'h34);
    rd(HI); `CHK(r[7:0], 8'h34)
    // High byte first, so the running low byte cannot carry into it.
    wr(HI, 8'hFF);
    wr(LO, 8'hFE);
    repeat (10) @(posedge pclk);
    wr(CTRL, 8'h00);
    `CHK(ovf, 3'h1)
    rd(STAT); `CHK(r, 32'h0000_0001)
    rd(HI); `CHK(r[7:0], 8'h00)
    wr(STAT, 8'h01); `CHK(ovf[0], 1'b0)
    run_pin(8'h81, 16'h0, 5); `CHK(c2, 16'h0004)
    run_pin(8'h85, 16'h0, 5); `CHK(c2, 16'h0004)
    slp <= 1'b1;
    run_pin(8'h81, 16'h0, 5); `CHK(c2, 16'h0000)
    run_pin(8'h85, 16'hFFFF, 3); `CHK({wake_seen, c2}, 17'h10001)
    wr(STAT, 8'h01);
    wr(LO, 8'h00);
    wr(HI, 8'hFC);
    wr(CTRL, 8'h8D);
    w = 0;
    while (ovf[0] !== 1'b1 && w < 30000) begin
      @(posedge pclk);
      w = w + 1;
    end
    `CHK({ovf[0], sosc_on, xo_seen}, 3'h7)
    `CHK(w >= 20000, 1'b1)
    wr(CTRL, 8'h00);
    end_sim;
  end
endmodule
